// *** bench/cbt_host_assertions.sv ***
// port checker for the training sequencer
`timescale 1ns/100ps
`include "cbt_host_defines.vh"
module cbt_host_checker
(
   // clock and reset
   input wire clk,
   input wire arst_n,
   // software port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   input wire [31:0] rdata,
   // sdram pins
   input wire ck,
   input wire [1:0] cke,
   input wire [1:0] cs,
   input wire [5:0] ca,
   input wire dqs,
   input wire dqs_oe,
   input wire [6:0] dq_out,
   input wire dq_oe,
   input wire [13:0] dq_in
);
   reg ck_q;
   reg dqs_q;
   reg [3:0] run;
   reg [3:0] half;
   reg [3:0] edges;
   reg [15:0] low_age;
   reg [15:0] hi_age;
   reg [15:0] quiet;
   reg [15:0] desel;
   reg [15:0] settle;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ck half period, strobe edges, cycle ages
   always @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ck_q <= 1'b0;
         dqs_q <= 1'b0;
         run <= 4'h0;
         half <= 4'h0;
         edges <= 4'h0;
         low_age <= 16'h0;
         hi_age <= 16'hFFFF;
         quiet <= 16'hFFFF;
         desel <= 16'hFFFF;
         settle <= 16'h0;
      end
      else
      begin
         ck_q <= ck;
         dqs_q <= dqs;
         run <= (ck != ck_q) ? 4'h1 : run + {3'h0, ~&run};
         half <= (ck != ck_q) ? run : half;
         edges <= !dq_oe ? 4'h0 : edges + {3'h0, dqs != dqs_q};
         low_age <= (cke == 2'b11) ? 16'h0 : low_age + {15'h0, ~&low_age};
         hi_age <= (cke != 2'b11) ? 16'h0 : hi_age + {15'h0, ~&hi_age};
         quiet <= (cs != 2'h0) ? 16'h0 : quiet + {15'h0, ~&quiet};
         desel <= (cs != 2'h0 || ca != 6'h00) ? 16'h0 :
            desel + {15'h0, ~&desel};
         settle <= (dqs != dqs_q) ? 16'h0 : settle + {15'h0, ~&settle};
      end
   end
   chk_cmd_held_low: assert property (
      (cs != 2'h0 || ca != 6'h00) && low_age != 16'h0 |-> low_age > 40)
      else $error("command pins moved too soon after cke fall");
   chk_ck_rate_kept: assert property (
      ck != ck_q && low_age != 16'h0 && low_age < 40 |-> run == half)
      else $error("ck rate changed before cke low delay");
   chk_exit_slow_ck: assert property (
      $rose(cke[0]) || $rose(cke[1]) |-> half == `CK_HALF_SLOW)
      else $error("cke raised without original ck rate");
   chk_exit_deselect: assert property (
      $rose(cke[0]) || $rose(cke[1]) |-> desel >= 60)
      else $error("cs or ca not low long enough before cke high");
   chk_entry_mrd: assert property (
      $fell(cke[0]) || $fell(cke[1]) |-> quiet >= 40)
      else $error("cke lowered too soon after mode write");
   chk_two_pulses: assert property (
      $fell(dq_oe) |-> edges >= 4'h4)
      else $error("fewer than two strobe pulses");
   chk_ref_static: assert property (
      dq_oe && $past(dq_oe) |-> $stable(dq_out))
      else $error("reference value moved while driven");
   chk_settle_min: assert property (
      $fell(dq_oe) |-> settle >= 80)
      else $error("reference released before short settle");
   chk_exit_settle: assert property (
      cs != 2'h0 && cke == 2'b11 |-> hi_age >= 250)
      else $error("command issued too soon after cke high");
   cov_rank1_exit: cover property ($rose(cke[1]));
   cov_ref_done: cover property ($fell(dq_oe));
   cov_pattern: cover property (cs != 2'h0 && cke != 2'b11);
endmodule // cbt_host_checker

bind cbt_host cbt_host_checker cbt_host_checker_inst
(
   .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .ck(ck), .cke(cke), .cs(cs), .ca(ca),
   .dqs(dqs), .dqs_oe(dqs_oe), .dq_out(dq_out), .dq_oe(dq_oe),
   .dq_in(dq_in)
);

// *** bench/sdram_model.sv ***
// behavioural two-rank sdram for command bus training
`timescale 1ns/100ps
`include "cbt_host_defines.vh"
module sdram_model
#(
   parameter TERM_RANK = 1
)
(
   // command pins
   input wire ck,
   input wire [1:0] cke,
   input wire [1:0] cs,
   input wire [5:0] ca,
   // data pins
   input wire dqs,
   input wire dqs_oe,
   input wire [6:0] dq_out,
   input wire dq_oe,
   output wire [13:0] dq_in
);
   reg [7:0] mr13 [0:1];
   reg [6:0] mr12 [0:1];
   reg [6:0] vtmp;
   reg [5:0] echo;
   reg [5:0] ma;
   reg [1:0] ph;
   reg [1:0] rks;
   reg op7;
   reg op6;
   reg flag;
   integer i;
   wire [1:0] cbt = {mr13[1][0] & ~cke[1], mr13[0][0] & ~cke[0]};
   // set in use: alternate while cke low in training
   wire [1:0] fsp_use = {mr13[1][7], mr13[0][7]} ^ cbt;
   // released echo lines show the inverse, not the last value
   assign dq_in = {cbt != 2'b00 ? echo : ~echo, flag, ~dq_out};
   initial
   begin
      mr13[0] = 8'h00;
      mr13[1] = 8'h00;
      ph = 2'h0;
      flag = 1'b0;
      echo = 6'h00;
      vtmp = 7'h00;
   end
   always @(posedge ck)
   begin
      if (ph == 2'h0 && (cs & cbt) != 2'b00)
         echo <= ca;
      else if (ph == 2'h0 && (cs & cke) != 2'b00)
      begin
         // cke low blocks decoding
         rks <= cs & cke;
         flag <= ~flag;
         // op7 rides on the first part, op6 on the second
         if ({1'b0, ca[4:0]} == `CA_MRW1)
         begin
            op7 <= ca[5];
            ph <= 2'h1;
         end
         else if ({1'b0, ca[4:0]} == `CA_MRW2)
         begin
            op6 <= ca[5];
            ph <= 2'h2;
         end
         else if (ca == `CA_MRR)
            ph <= 2'h3;
      end
      else if (ph == 2'h1)
      begin
         ma <= ca;
         ph <= 2'h0;
      end
      else if (ph == 2'h2)
      begin
         for (i = 0; i < 2; i = i + 1)
            if (rks[i] && ma == `MA_MR13)
               mr13[i] <= {op7, op6, ca};
            else if (rks[i] && ma == `MA_MR12)
               mr12[i] <= {op6, ca};
         ph <= 2'h0;
      end
      else if (ph == 2'h3)
      begin
         flag <= (rks[TERM_RANK] != 1'b0);
         ph <= 2'h0;
      end
   end
   // every strobe edge with dqs_oe and dq_oe high while a rank is in training overwrites the captured reference
   always @(dqs)
      if (dqs_oe && dq_oe && cbt != 2'b00)
         vtmp <= dq_out;
endmodule // sdram_model

// *** bench/tb_cbt_host.sv ***
// self-checking bench for the training sequencer
`timescale 1ns/100ps
`include "cbt_host_defines.vh"
module tb_cbt_host;
   reg clk = 1'b0;
   reg arst_n = 1'b0;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   wire [31:0] rdata;
   wire ck, dqs, dqs_oe, dq_oe;
   wire [1:0] cke, cs;
   wire [5:0] ca;
   wire [6:0] dq_out;
   wire [13:0] dq_in;
   integer error_cnt = 0;
   integer tests_run = 0;
   integer i;
   cbt_host cbt_host_inst
   (
      .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .ck(ck), .cke(cke), .cs(cs), .ca(ca),
      .dqs(dqs), .dqs_oe(dqs_oe), .dq_out(dq_out), .dq_oe(dq_oe),
      .dq_in(dq_in)
   );
   sdram_model #(.TERM_RANK(1)) sdram_model_inst
   (
      .ck(ck), .cke(cke), .cs(cs), .ca(ca), .dqs(dqs), .dqs_oe(dqs_oe),
      .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in)
   );
   always #5 clk = ~clk;
   task wr_reg(input [7:0] a, input [31:0] d);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   end
   endtask
   task rd_reg(input [7:0] a, output [31:0] d);
   begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp, input [31:0] m);
   begin
      tests_run = tests_run + 1;
      if ((got & m) !== (exp & m))
      begin
         error_cnt = error_cnt + 1;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   end
   endtask
   task rd_chk(input [7:0] a, input [31:0] exp, input [31:0] m);
      reg [31:0] d;
   begin
      rd_reg(a, d);
      chk(d, exp, m);
   end
   endtask
   // poll status until state and step match with busy clear
   task wait_st(input [31:0] exp);
      reg [31:0] d;
      integer n;
   begin
      d = 32'h0;
      for (n = 0; n < 20000 && (d & 32'h01FFF000) !== exp; n = n + 1)
         rd_reg(`REG_STAT, d);
      chk(d, exp, 32'h01FFF000);
   end
   endtask
   task end_of_test;
   begin
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   initial
   begin
      // sequence needs a few thousand cycles; ample margin here
      #300000;
      error_cnt = error_cnt + 1;
      end_of_test;
   end
   initial
   begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      rd_chk(`REG_STAT, 32'h0004_0000, 32'h01FFF001);
      rd_chk(`REG_VREFRB, 32'h26CD, 32'h3FFF);
      rd_chk(8'h14, 32'h0, 32'hFFFFFFFF);
      wr_reg(`REG_CAPAT, 32'h15);
      rd_chk(`REG_CAPAT, 32'h0, 32'h3F);
      wr_reg(`REG_CTRL, 32'h1);
      wait_st(32'h0080A000);
      rd_chk(`REG_STAT, 32'h201, 32'h201);
      chk(sdram_model_inst.mr13[0], 32'h40, 32'hFF);
      wr_reg(`REG_VREF, 32'h14E);
      wait_st(32'h0080A000);
      chk(sdram_model_inst.vtmp, 32'h4E, 32'h7F);
      for (i = 0; i < 6; i = i + 1)
      begin
         wr_reg(`REG_CAPAT, 32'h1 << i);
         wait_st(32'h0080A000);
         rd_chk(`REG_STAT, (32'h1 << (i + 2)) | 32'h100, 32'h1FC);
      end
      wr_reg(`REG_CTRL, 32'h2);
      wait_st(32'h0081A000);
      chk(sdram_model_inst.mr12[1], 32'h4E, 32'h7F);
      chk(sdram_model_inst.mr13[0], 32'h41, 32'hFF);
      chk(sdram_model_inst.mr13[1], 32'hC0, 32'hFF);
      wr_reg(`REG_CTRL, 32'h2);
      rd_chk(`REG_STAT, 32'h0081A000, 32'h01FFF000);
      wr_reg(`REG_VREF, 32'h050);
      wait_st(32'h0081A000);
      chk(sdram_model_inst.vtmp, 32'h50, 32'h7F);
      chk(sdram_model_inst.fsp_use, 32'h3, 32'h3);
      wr_reg(`REG_CAPAT, 32'h2A);
      wait_st(32'h0081A000);
      rd_chk(`REG_STAT, 32'h1A8, 32'h1FC);
      wr_reg(`REG_CTRL, 32'h2);
      wait_st(32'h01028000);
      rd_chk(`REG_STAT, 32'h801, 32'hC01);
      rd_chk(`REG_VREFRB, 32'h2750, 32'h3FFF);
      chk(sdram_model_inst.mr12[0], 32'h50, 32'h7F);
      chk(sdram_model_inst.mr13[0], 32'h40, 32'hFF);
      chk(sdram_model_inst.mr13[1], 32'hC0, 32'hFF);
      chk(sdram_model_inst.fsp_use, 32'h2, 32'h3);
      end_of_test;
   end
endmodule // tb_cbt_host

// *** src/cbt_host.v ***
// multi-rank command bus training sequencer, controller side
`timescale 1ns/100ps
`include "cbt_host_defines.vh"
module cbt_host
(
   // clock and reset
   input wire clk,
   input wire arst_n,
   // software port
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire wr,
   input wire rd,
   output reg [31:0] rdata,
   // sdram command pins
   output wire ck,
   output reg [1:0] cke,
   output reg [1:0] cs,
   output reg [5:0] ca,
   // sdram data pins
   output reg dqs,
   output reg dqs_oe,
   output reg [6:0] dq_out,
   output reg dq_oe,
   input wire [13:0] dq_in
);

localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_GO = 7'h02;
localparam [6:0] S_CMD = 7'h04;
localparam [6:0] S_WAIT = 7'h08;
localparam [6:0] S_PIN = 7'h10;
localparam [6:0] S_TRAIN = 7'h20;
localparam [6:0] S_DONE = 7'h40;

localparam [3:0] K_DQS = 4'h1;
localparam [3:0] K_SETTLE = 4'h2;
localparam [3:0] K_CA = 4'h4;
localparam [3:0] K_ECHO = 4'h8;

localparam [11:0] C_MRD = `NS2CYC(`T_MRD_NS);
localparam [11:0] C_CKELCK = `NS2CYC(`T_CKELCK_NS);
localparam [11:0] C_PRECS = `NS2CYC(`T_CKPRECS_NS);
localparam [11:0] C_CKCKEH = `NS2CYC(`T_CKCKEH_NS);
localparam [11:0] C_VLONG = `NS2CYC(`T_VREF_LONG_NS);
localparam [11:0] C_VSHORT = `NS2CYC(`T_VREF_SHORT_NS);
localparam [11:0] C_MRR = `NS2CYC(`T_MRR_NS);
localparam [11:0] C_ECHO = `NS2CYC(`T_ECHO_NS);

reg [6:0] state;
reg [4:0] step;
reg [1:0] ph;
reg [2:0] cph;
reg [11:0] tmr;
reg fast;
reg [1:0] term;
reg [6:0] vref0;
reg [6:0] vref1;
reg vref_seen;
reg tbusy;
reg [3:0] tkind;
reg [2:0] dqs_cnt;
reg short_ok;
reg [5:0] echo;
reg [5:0] capat;
reg [13:0] dq_m;
reg [13:0] dq_s;
reg [2:0] act;
reg [2:0] rs;
reg [2:0] os;
reg [1:0] rmask;
reg [5:0] ma;
reg [7:0] op;
reg [5:0] cmd_ca;

wire ck_fall;
wire term_sel;
wire [1:0] tm;
wire is_mrr;
wire [2:0] cmd_last;
wire [6:0] vref_cur;
wire [6:0] vref_new;
wire one_step;

ck_divider u_ck
(
   .clk(clk),
   .arst_n(arst_n),
   .fast(fast),
   .ck(ck),
   .ck_fall(ck_fall)
);

// terminating die from MR0 reads; rank 0 when neither reports
assign term_sel = ~term[0] & term[1];
assign tm = term_sel ? 2'b10 : 2'b01;
assign is_mrr = (act == `ACT_MRR);
assign cmd_last = is_mrr ? 3'h2 : 3'h4;
assign vref_cur = rmask[1] ? vref1 : vref0;
assign vref_new = wdata[6:0];
assign one_step = (vref_new == vref_cur + 7'h01) ||
   (vref_cur == vref_new + 7'h01);

// the multi-rank sequence, one action per step
always @*
begin
   case (step)
   5'h00: {act, rs, os} = {`ACT_MRW, `RS_ALL, `OS_WR1};
   5'h01: {act, rs, os} = {`ACT_MRR, `RS_R0, `OS_MR0};
   5'h02: {act, rs, os} = {`ACT_MRR, `RS_R1, `OS_MR0};
   5'h03: {act, rs, os} = {`ACT_MRW, `RS_T, `OS_CBT};
   5'h04: {act, rs, os} = {`ACT_CKEL, `RS_T, `OS_WR1};
   5'h05: {act, rs, os} = {`ACT_TRAIN, `RS_T, `OS_WR1};
   5'h06: {act, rs, os} = {`ACT_EXIT, `RS_T, `OS_WR1};
   5'h07: {act, rs, os} = {`ACT_MRW, `RS_T, `OS_WR1};
   5'h08: {act, rs, os} = {`ACT_MRW, `RS_T, `OS_VREF};
   5'h09: {act, rs, os} = {`ACT_MRW, `RS_N, `OS_CBT};
   5'h0A: {act, rs, os} = {`ACT_MRW, `RS_T, `OS_OP1};
   5'h0B: {act, rs, os} = {`ACT_FAST, `RS_T, `OS_WR1};
   5'h0C: {act, rs, os} = {`ACT_CKEL, `RS_N, `OS_WR1};
   5'h0D: {act, rs, os} = {`ACT_TRAIN, `RS_N, `OS_WR1};
   5'h0E: {act, rs, os} = {`ACT_MRW, `RS_T, `OS_WR1};
   5'h0F: {act, rs, os} = {`ACT_EXIT, `RS_N, `OS_WR1};
   5'h10: {act, rs, os} = {`ACT_MRW, `RS_N, `OS_WR1};
   5'h11: {act, rs, os} = {`ACT_MRW, `RS_N, `OS_VREF};
   5'h12: {act, rs, os} = {`ACT_MRW, `RS_T, `OS_OP1};
   5'h13: {act, rs, os} = {`ACT_FAST, `RS_T, `OS_WR1};
   default: {act, rs, os} = {`ACT_END, `RS_ALL, `OS_WR1};
   endcase
end

always @*
begin
   case (rs)
   `RS_T: rmask = tm;
   `RS_N: rmask = ~tm;
   `RS_R0: rmask = 2'b01;
   `RS_R1: rmask = 2'b10;
   default: rmask = 2'b11;
   endcase
   case (os)
   `OS_CBT: {ma, op} = {`MA_MR13, `MR13_CBT};
   `OS_OP1: {ma, op} = {`MA_MR13, `MR13_OP1};
   `OS_VREF: {ma, op} = {`MA_MR12, 1'b0, vref_cur};
   `OS_MR0: {ma, op} = {`MA_MR0, 8'h00};
   default: {ma, op} = {`MA_MR13, `MR13_WR1};
   endcase
   case (cph)
   3'h0: cmd_ca = is_mrr ? `CA_MRR : (`CA_MRW1 | {op[7], 5'h00});
   3'h1: cmd_ca = ma;
   3'h2: cmd_ca = `CA_MRW2 | {op[6], 5'h00};
   default: cmd_ca = op[5:0];
   endcase
end

// data pins come from another domain
always @(posedge clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      dq_m <= 14'h0000;
      dq_s <= 14'h0000;
   end
   else
   begin
      dq_m <= dq_in;
      dq_s <= dq_m;
   end
end

always @(posedge clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      state <= S_IDLE;
      step <= 5'h00;
      ph <= 2'h0;
      cph <= 3'h0;
      tmr <= 12'h000;
      fast <= 1'b0;
      cke <= 2'b11;
      cs <= 2'b00;
      ca <= `CA_DESEL;
      dqs <= 1'b0;
      dqs_oe <= 1'b0;
      dq_out <= 7'h00;
      dq_oe <= 1'b0;
      term <= 2'b00;
      vref0 <= `VREF_INIT;
      vref1 <= `VREF_INIT;
      vref_seen <= 1'b0;
      tbusy <= 1'b0;
      tkind <= K_DQS;
      dqs_cnt <= 3'h0;
      short_ok <= 1'b0;
      echo <= 6'h00;
      capat <= 6'h00;
   end
   else
   begin
      if (tmr != 12'h000)
         tmr <= tmr - 12'h001;
      case (state)
      S_IDLE, S_DONE:
         if (wr && addr == `REG_CTRL && wdata[`CTRL_START])
         begin
            step <= 5'h00;
            term <= 2'b00;
            state <= S_GO;
         end
      S_GO:
      begin
         ph <= 2'h0;
         cph <= 3'h0;
         vref_seen <= 1'b0;
         case (act)
         `ACT_MRW, `ACT_MRR: state <= S_CMD;
         `ACT_TRAIN: state <= S_TRAIN;
         `ACT_END: state <= S_DONE;
         default: state <= S_PIN;
         endcase
      end
      // MRW in two parts, MRR in one, CS high on the first CK of each part
      S_CMD:
         if (ck_fall)
         begin
            cph <= cph + 3'h1;
            cs <= 2'b00;
            ca <= `CA_DESEL;
            if (cph == cmd_last)
            begin
               tmr <= is_mrr ? C_MRR : C_MRD;
               state <= S_WAIT;
            end
            else
            begin
               cs <= cph[0] ? 2'b00 : rmask;
               ca <= cmd_ca;
            end
         end
      S_WAIT:
         if (tmr == 12'h000)
         begin
            if (is_mrr)
               term <= term | (rmask & {2{dq_s[`DQ_TERM_BIT]}});
            step <= step + 5'h01;
            state <= S_GO;
         end
      S_PIN:
         case (ph)
         2'h0:
         begin
            ph <= 2'h1;
            cs <= 2'b00;
            ca <= `CA_DESEL;
            if (act == `ACT_CKEL)
            begin
               cke <= cke & ~rmask;
               tmr <= C_CKELCK;
            end
            else if (act == `ACT_EXIT)
            begin
               fast <= 1'b0;
               tmr <= C_CKCKEH;
            end
            else
            begin
               fast <= 1'b1;
               tmr <= C_PRECS;
            end
         end
         2'h1:
            if (tmr == 12'h000)
            begin
               if (act == `ACT_FAST)
               begin
                  step <= step + 5'h01;
                  state <= S_GO;
               end
               else
                  ph <= 2'h2;
            end
         2'h2:
         begin
            ph <= 2'h3;
            if (act == `ACT_CKEL)
            begin
               fast <= 1'b1;
               tmr <= C_PRECS;
            end
            else
            begin
               cke <= cke | rmask;
               tmr <= C_VLONG;
            end
         end
         default:
            if (tmr == 12'h000)
            begin
               step <= step + 5'h01;
               state <= S_GO;
            end
         endcase
      S_TRAIN:
         if (!tbusy)
         begin
            if (wr && addr == `REG_VREF)
            begin
               dq_out <= vref_new;
               dq_oe <= 1'b1;
               dqs_oe <= 1'b1;
               dqs_cnt <= `DQS_EDGES;
               short_ok <= wdata[`VREF_SHORT] && one_step;
               if (rmask[1])
                  vref1 <= vref_new;
               else
                  vref0 <= vref_new;
               vref_seen <= 1'b1;
               tbusy <= 1'b1;
               tkind <= K_DQS;
            end
            else if (wr && addr == `REG_CAPAT)
            begin
               capat <= wdata[5:0];
               cph <= 3'h0;
               tbusy <= 1'b1;
               tkind <= K_CA;
            end
            else if (wr && addr == `REG_CTRL && wdata[`CTRL_NEXT] &&
               vref_seen)
            begin
               step <= step + 5'h01;
               state <= S_GO;
            end
         end
         else
            case (tkind)
            K_DQS:
               if (ck_fall)
               begin
                  if (dqs_cnt != 3'h0)
                  begin
                     dqs <= ~dqs;
                     dqs_cnt <= dqs_cnt - 3'h1;
                  end
                  else
                  begin
                     tmr <= short_ok ? C_VSHORT : C_VLONG;
                     tkind <= K_SETTLE;
                  end
               end
            K_SETTLE:
               if (tmr == 12'h000)
               begin
                  tbusy <= 1'b0;
                  dq_oe <= 1'b0;
                  dqs_oe <= 1'b0;
               end
            K_CA:
               if (ck_fall)
               begin
                  cph <= 3'h1;
                  cs <= rmask;
                  ca <= capat;
                  if (cph != 3'h0)
                  begin
                     cs <= 2'b00;
                     ca <= `CA_DESEL;
                     tmr <= C_ECHO;
                     tkind <= K_ECHO;
                  end
               end
            default:
               if (tmr == 12'h000)
               begin
                  echo <= dq_s[13:8];
                  tbusy <= 1'b0;
               end
            endcase
      default:
         state <= S_IDLE;
      endcase
   end
end

// read data stands only in the cycle after the strobe
always @(posedge clk or negedge arst_n)
begin
   if (!arst_n)
      rdata <= 32'h00000000;
   else if (rd && addr == `REG_STAT)
      rdata <= {7'h00, state, step, tbusy, term, term_sel,
         (echo == capat), echo, vref_seen, fast};
   else if (rd && addr == `REG_VREFRB)
      rdata <= {18'h00000, vref1, vref0};
   else if (rd && addr == `REG_CAPAT)
      rdata <= {26'h0000000, capat};
   else
      rdata <= 32'h00000000;
end

endmodule // cbt_host

// *** src/cbt_host_defines.vh ***
// constants for the command bus training host sequencer
// Functional notes
// - set FSP write-select in MR13 first
// - read MR0 bit7, find terminating die
// - enter training on terminating rank first
// - CKE low, then raise CK frequency
// - exit: slow CK, CKE high, write trained values
// - enter training on other rank, CKE high
// - terminating rank to FSP1, fast CK, CKE low
// - terminating rank back to FSP0 before exit
// - write trained values, switch FSP, fast CK
// - change CK only after CKE-low delay
// - hold CK, CS, CA low after CKE falls; CK keeps toggling here
// - at least two strobe pulses per setting
// - short settle only for single-step setting
// - program alternate set point before training
// - valid original-rate CK before CKE high
// - CS and CA low before CKE high
// - trained values lost, must be written back
// - training entry sets MR13 bit0 by MRW pair
// - exit: CKE high, long settle, clear bit0
`ifndef CBT_HOST_DEFINES_VH
`define CBT_HOST_DEFINES_VH

// software registers
`define REG_CTRL 8'h00
`define REG_VREF 8'h04
`define REG_CAPAT 8'h08
`define REG_STAT 8'h0C
`define REG_VREFRB 8'h10
`define CTRL_START 0
`define CTRL_NEXT 1
`define VREF_SHORT 8
`define VREF_INIT 7'h4D

// mode registers and values
`define MA_MR0 6'h00
`define MA_MR12 6'h0C
`define MA_MR13 6'h0D
`define MR13_WR1 8'h40
`define MR13_CBT 8'h41
`define MR13_OP1 8'hC0
`define DQ_TERM_BIT 7

// command bus encodings
`define CA_MRW1 6'h06
`define CA_MRW2 6'h16
`define CA_MRR 6'h0E
`define CA_DESEL 6'h00

// sequence actions, rank selects, operand selects
`define ACT_MRW 3'h0
`define ACT_MRR 3'h1
`define ACT_CKEL 3'h2
`define ACT_TRAIN 3'h3
`define ACT_EXIT 3'h4
`define ACT_FAST 3'h5
`define ACT_END 3'h6
`define RS_ALL 3'h0
`define RS_T 3'h1
`define RS_N 3'h2
`define RS_R0 3'h3
`define RS_R1 3'h4
`define OS_WR1 3'h0
`define OS_CBT 3'h1
`define OS_OP1 3'h2
`define OS_VREF 3'h3
`define OS_MR0 3'h4

// timing, ns, and clock
`define CLK_NS 10
`define T_MRD_NS 400
`define T_CKELCK_NS 400
`define T_CKPRECS_NS 400
`define T_CKCKEH_NS 600
`define T_VREF_LONG_NS 2500
`define T_VREF_SHORT_NS 800
`define T_MRR_NS 600
`define T_ECHO_NS 200
`define NS2CYC(t) (((t) + `CLK_NS - 1) / `CLK_NS)
`define CK_HALF_SLOW 4'h8
`define CK_HALF_FAST 4'h2
`define DQS_EDGES 3'h4

`endif

// *** src/ck_divider.v ***
// link clock divider with slow and fast rates
`timescale 1ns/100ps
`include "cbt_host_defines.vh"
module ck_divider
(
   // clock and reset
   input wire clk,
   input wire arst_n,
   // rate select
   input wire fast,
   // link clock and its falling-edge enable
   output reg ck,
   output reg ck_fall
);

reg [3:0] cnt;
reg sel;
wire [3:0] half;

assign half = sel ? `CK_HALF_FAST : `CK_HALF_SLOW;

// rate changes only at a toggle, so no runt phase reaches the pin
always @(posedge clk or negedge arst_n)
begin
   if (!arst_n)
   begin
      cnt <= 4'h0;
      sel <= 1'b0;
      ck <= 1'b0;
      ck_fall <= 1'b0;
   end
   else if (cnt == half - 4'h1)
   begin
      cnt <= 4'h0;
      ck <= ~ck;
      ck_fall <= ck;
      sel <= fast;
   end
   else
   begin
      cnt <= cnt + 4'h1;
      ck_fall <= 1'b0;
   end
end

endmodule // ck_divider
